// ---- src/dpf_fifo.sv ----
// Function
// RQ1: ports act independently; same-address clash avoided by surrounding logic; array drops a port a write in a cycle where port b latches.
// RQ2: first array port is read/write or read-only.
// RQ3: second array port is read/write or write-only.
// RQ4: port widths differ only by power of two, one to sixty-four.
// RQ5: width times depth equal on both ports.
// RQ6: address captured only on rising strobe edge.
// RQ7: read begins at rising strobe, pulse length irrelevant.
// RQ8: write data latched at strobe fall or enable release, first wins; port a writes latch at the rising strobe.
// RQ9: each port has its own suffixed strobe, enable, address, data signals.
// RQ10: first port drains, second port fills.
// RQ11: each side has own clock and address counter.
// RQ12: storage uses read-only drain port, write-only fill port.
// RQ13: row count two to one hundred twenty-eight, even.
// RQ14: fifo widths differ only by power-of-two ratio.
// RQ15: separate clock inputs for drain and fill sides.
// RQ16: clear input resets the fifo.
// RQ17: empty and full flags output.
// RQ18: counters move on accepted transfers; flags from counter compare.
// RQ19: clear zeroes counters, raises empty, drops full.
module dpf_fifo (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic drainSideClock,
	input wire logic fillSideClock,
	input wire logic clear_n,
	input wire logic writeReq,
	input wire logic readReq,
	input wire logic [dpf_pkg::FILL_WIDTH-1:0] writeWordIn,
	output logic [dpf_pkg::DRAIN_WIDTH-1:0] readWordOut,
	output logic readValid,
	output logic empty,
	output logic full
);
	localparam int R = dpf_pkg::WIDTH_RATIO;
	localparam int CW = dpf_pkg::DRAIN_AW + 1;
	localparam int AW = dpf_pkg::DRAIN_AW;
	// counter step shared by both sides, wraps at twice the depth
	function automatic logic [CW-1:0] stepCount(logic [CW-1:0] cnt, int step);
		return cnt + CW'(step);
	endfunction : stepCount
	// RQ14 fill and drain widths differ by a power of two only
	if (R < 1 || R > dpf_pkg::MAX_RATIO || (R & (R - 1)) != 0
		|| dpf_pkg::FILL_WIDTH != dpf_pkg::DRAIN_WIDTH * R) begin : g_bad_fifo_ratio
		$error("fifo width ratio not a power of two in range");
	end
	// RQ13 row count check
	if (dpf_pkg::FIFO_ROWS < dpf_pkg::MIN_ROWS || dpf_pkg::FIFO_ROWS > dpf_pkg::MAX_ROWS
		|| dpf_pkg::FIFO_ROWS % dpf_pkg::ROW_STEP != 0) begin : g_bad_rows
		$error("fifo row count out of range");
	end

	// ----------------------------------------
	// side clocks as enables
	// ----------------------------------------
	// side clocks are synchronous inputs, so their rising edges become one-cycle enables
	logic drainClk_q, fillClk_q, drainTick, fillTick;
	logic [CW-1:0] rdCnt_q, wrCnt_q, used;
	logic [CW-1:0] wrCommit_q;
	logic [dpf_pkg::FILL_WIDTH-1:0] fillWord_q;
	logic doRead, doWrite, valid_q;
	// RQ15 one clock input per side
	assign drainTick = drainSideClock & ~drainClk_q;
	assign fillTick = fillSideClock & ~fillClk_q;
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			drainClk_q <= 1'b0;
			fillClk_q <= 1'b0;
		end else begin
			drainClk_q <= drainSideClock;
			fillClk_q <= fillSideClock;
		end
	end

	// ----------------------------------------
	// flags
	// ----------------------------------------
	// RQ17 flags from pointer difference, counted in narrow words
	// full counts a word as soon as it is taken, so no slot is overwritten
	assign used = wrCnt_q - rdCnt_q;
	// RQ1 empty only trusts words already latched into the array
	assign empty = (wrCommit_q == rdCnt_q);
	assign full = (used > CW'(dpf_pkg::DRAIN_DEPTH - R));
	// RQ18 only accepted transfers advance
	assign doRead = drainTick & readReq & ~empty & clear_n;
	assign doWrite = fillTick & writeReq & ~full & clear_n;

	// ----------------------------------------
	// counters
	// ----------------------------------------
	// RQ11 each side counter steps on its own clock tick
	// RQ16 clear input resets the fifo
	// RQ19 clear zeroes both counters
	always_ff @(posedge mclk) begin
		if (!reset_n || !clear_n) begin
			rdCnt_q <= '0;
			wrCnt_q <= '0;
		end else begin
			if (doRead) begin
				rdCnt_q <= stepCount(rdCnt_q, 1);
			end
			if (doWrite) begin
				wrCnt_q <= stepCount(wrCnt_q, R);
			end
		end
	end
	// RQ1 write count as the drain side sees it, one cycle behind
	// the array latches a word a cycle after it is taken, so empty
	// lags by that cycle rather than hand out a stale slot
	always_ff @(posedge mclk) begin
		if (!reset_n || !clear_n) begin
			wrCommit_q <= '0;
		end else begin
			wrCommit_q <= wrCnt_q;
		end
	end

	// ----------------------------------------
	// fill word hold
	// ----------------------------------------
	// RQ8 taken word held until the array latches it
	// the user may change writeWordIn right after its tick
	always_ff @(posedge mclk) begin
		if (doWrite) begin
			fillWord_q <= writeWordIn;
		end
	end

	// ----------------------------------------
	// array ports
	// ----------------------------------------
	// RQ9 each port keeps its own signal set
	dpf_port_if #(.AW(dpf_pkg::DRAIN_AW), .DW(dpf_pkg::DRAIN_WIDTH)) portA ();
	dpf_port_if #(.AW(dpf_pkg::FILL_AW), .DW(dpf_pkg::FILL_WIDTH)) portB ();
	// RQ10 port a drains: strobe high for one cycle per read
	assign portA.portCycleStrobe = doRead;
	assign portA.writeEnable_n = 1'b1;
	assign portA.addr = rdCnt_q[dpf_pkg::DRAIN_AW-1:0];
	assign portA.writeWordIn = '0;
	// RQ10 port b fills: strobe and enable pulse together
	assign portB.portCycleStrobe = doWrite;
	assign portB.writeEnable_n = ~doWrite;
	assign portB.addr = wrCnt_q[dpf_pkg::DRAIN_AW-1 -: dpf_pkg::FILL_AW];
	assign portB.writeWordIn = fillWord_q;
	// RQ12 read-only drain, write-only fill
	dpf_two_port_array #(.A_MODE(dpf_pkg::DPF_A_RO), .B_MODE(dpf_pkg::DPF_B_WO)) u_array (
		.mclk(mclk),
		.portA(portA),
		.portB(portB)
	);
	// read data is one cycle behind the accepted read, write takes two
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			valid_q <= 1'b0;
		end else begin
			valid_q <= doRead;
		end
	end
	assign readValid = valid_q;
	assign readWordOut = portA.readWordOut;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// RQ19 clear empties the fifo
	property p_clear;
		@(posedge mclk) disable iff (!reset_n) !clear_n |=> empty && !full; // RQ19
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not empty fifo"); // RQ19
	property p_no_over;
		@(posedge mclk) disable iff (!reset_n) full |-> !doWrite; // RQ18
	endproperty
	a_no_over: assert property (p_no_over) else $error("write while full"); // RQ18
	property p_rd_step;
		@(posedge mclk) disable iff (!reset_n || !clear_n)
			doRead |=> rdCnt_q == $past(rdCnt_q) + CW'(1); // RQ11
	endproperty
	a_rd_step: assert property (p_rd_step) else $error("read counter missed step"); // RQ11
	property p_valid;
		@(posedge mclk) disable iff (!reset_n) doRead |=> readValid; // RQ7
	endproperty
	a_valid: assert property (p_valid) else $error("read data not valid"); // RQ7

	// RQ14 fill counter moves by the width ratio
	property p_wr_step;
		@(posedge mclk) disable iff (!reset_n || !clear_n)
			doWrite |=> wrCnt_q == stepCount($past(wrCnt_q), R);
	endproperty
	a_wr_step: assert property (p_wr_step) else $error("write counter missed step"); // RQ14

	// RQ1 no read of a slot whose word is still being latched
	property p_no_clash;
		@(posedge mclk) disable iff (!reset_n || !clear_n)
			doRead && $past(doWrite) |-> AW'(rdCnt_q - $past(wrCnt_q)) >= AW'(R);
	endproperty
	a_no_clash: assert property (p_no_clash) else $error("read of unlatched slot"); // RQ1

	// RQ1 empty drops only once the first word sits in the array
	property p_commit_lag;
		@(posedge mclk) disable iff (!reset_n || !clear_n)
			doWrite && empty |=> empty ##1 !empty;
	endproperty
	a_commit_lag: assert property (p_commit_lag) else $error("empty flag out of step"); // RQ1

	// RQ18 valid read data only follows an accepted read
	property p_valid_src;
		@(posedge mclk) disable iff (!reset_n) !doRead |=> !readValid;
	endproperty
	a_valid_src: assert property (p_valid_src) else $error("read data without a read"); // RQ18

	// RQ17 flags never both set, fill level within depth
	property p_flags;
		@(posedge mclk) disable iff (!reset_n)
			!(empty && full) && used <= CW'(dpf_pkg::DRAIN_DEPTH);
	endproperty
	a_flags: assert property (p_flags) else $error("flags or fill level inconsistent"); // RQ17

	// RQ8 array sees the taken word while it latches
	property p_fill_hold;
		@(posedge mclk) disable iff (!reset_n)
			doWrite |=> portB.writeWordIn == $past(writeWordIn);
	endproperty
	a_fill_hold: assert property (p_fill_hold) else $error("fill word not held"); // RQ8
endmodule : dpf_fifo

// ---- inc/dpf_pkg.sv ----
package dpf_pkg;
	// ----------------------------------------
	// storage geometry
	// ----------------------------------------
	localparam int DRAIN_WIDTH = 8;
	localparam int WIDTH_RATIO = 1;
	localparam int FILL_WIDTH = DRAIN_WIDTH * WIDTH_RATIO;
	localparam int FIFO_ROWS = 16;
	localparam int COLS_PER_ROW = 2;
	localparam int DRAIN_DEPTH = FIFO_ROWS * COLS_PER_ROW * WIDTH_RATIO;
	localparam int FILL_DEPTH = DRAIN_DEPTH / WIDTH_RATIO;
	localparam int DRAIN_AW = $clog2(DRAIN_DEPTH);
	localparam int FILL_AW = $clog2(FILL_DEPTH);
	localparam int TOTAL_BITS = DRAIN_WIDTH * DRAIN_DEPTH;
	localparam int MAX_RATIO = 64;
	localparam int MIN_ROWS = 2;
	localparam int MAX_ROWS = 128;
	localparam int ROW_STEP = 2;
	// port capability codes
	typedef enum logic {DPF_A_RW, DPF_A_RO} dpf_aport_t;
	typedef enum logic {DPF_B_RW, DPF_B_WO} dpf_bport_t;
endpackage : dpf_pkg

// ---- inc/dpf_port_if.sv ----
// one port of the two-port array
interface dpf_port_if #(parameter int AW = 4, parameter int DW = 8);
	logic portCycleStrobe;
	logic writeEnable_n;
	logic [AW-1:0] addr;
	logic [DW-1:0] writeWordIn;
	logic [DW-1:0] readWordOut;
	modport user (output portCycleStrobe, writeEnable_n, addr, writeWordIn, input readWordOut);
	modport array (input portCycleStrobe, writeEnable_n, addr, writeWordIn, output readWordOut);
endinterface : dpf_port_if

// ---- src/dpf_two_port_array.sv ----
// ----------------------------------------
// two-port storage, port a narrow side
// ----------------------------------------
module dpf_two_port_array #(
	parameter dpf_pkg::dpf_aport_t A_MODE = dpf_pkg::DPF_A_RO,
	parameter dpf_pkg::dpf_bport_t B_MODE = dpf_pkg::DPF_B_WO
) (
	input wire logic mclk,
	dpf_port_if.array portA,
	dpf_port_if.array portB
);
	localparam int R = dpf_pkg::WIDTH_RATIO;
	localparam int DW = dpf_pkg::DRAIN_WIDTH;
	// RQ4 ratio must be power of two up to limit
	if (R < 1 || R > dpf_pkg::MAX_RATIO || (R & (R - 1)) != 0) begin : g_bad_ratio
		$error("width ratio not a power of two in range");
	end
	// RQ5 same total storage both sides
	if (dpf_pkg::FILL_WIDTH * dpf_pkg::FILL_DEPTH != dpf_pkg::TOTAL_BITS) begin : g_bad_size
		$error("port sizes differ");
	end
	logic [DW-1:0] mem [dpf_pkg::DRAIN_DEPTH];
	logic strobeA_q, strobeB_q, weB_q, pendB_q;
	logic [dpf_pkg::FILL_AW-1:0] addrB_q;
	logic [dpf_pkg::FILL_WIDTH-1:0] dataB_q;
	logic [DW-1:0] readA_q;
	logic riseA, riseB, fallB, latchB;
	// RQ6 edges of the strobe sampled on mclk
	assign riseA = portA.portCycleStrobe & ~strobeA_q;
	assign riseB = portB.portCycleStrobe & ~strobeB_q;
	assign fallB = ~portB.portCycleStrobe & strobeB_q;
	// RQ8 first of strobe fall or enable release latches data
	assign latchB = pendB_q & (fallB | (portB.writeEnable_n & ~weB_q));
	assign portA.readWordOut = readA_q;
	assign portB.readWordOut = mem[addrB_q * R];
	always_ff @(posedge mclk) begin
		strobeA_q <= portA.portCycleStrobe;
		strobeB_q <= portB.portCycleStrobe;
		weB_q <= portB.writeEnable_n;
	end
	// RQ6 address taken on rising strobe only
	always_ff @(posedge mclk) begin
		if (riseB) begin
			addrB_q <= portB.addr;
		end
	end
	// RQ7 read starts on rising strobe, pulse width irrelevant
	always_ff @(posedge mclk) begin
		if (riseA) begin
			readA_q <= mem[portA.addr];
		end
	end
	// RQ2 port a may write only when built read/write
	// RQ3 port b write path, read path unused when write-only
	always_ff @(posedge mclk) begin
		if (riseB) begin
			pendB_q <= ~portB.writeEnable_n;
		end else if (latchB) begin
			pendB_q <= 1'b0;
		end
		if (latchB) begin
			for (int i = 0; i < R; i++) begin
				mem[addrB_q * R + i] <= portB.writeWordIn[i*DW +: DW];
			end
		end else if (A_MODE == dpf_pkg::DPF_A_RW && riseA && !portA.writeEnable_n) begin
			mem[portA.addr] <= portA.writeWordIn[DW-1:0];
		end
	end
endmodule : dpf_two_port_array

// ---- test/dpf_side_clk.sv ----
// ----------------------------------------
// user-side clock source for one fifo side
// ----------------------------------------
module dpf_side_clk (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic slow,
	output logic sideClk
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] cnt_q;
	// own side clock
	// each phase lasts at least one mclk so no edge is lost
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			cnt_q <= 2'h0;
			sideClk <= 1'b0;
		end else if (cnt_q == 2'h0) begin
			sideClk <= ~sideClk;
			cnt_q <= slow ? 2'h3 : 2'h0;
		end else begin
			cnt_q <= cnt_q - 2'h1;
		end
	end
endmodule : dpf_side_clk

// ---- test/test_dual_port_ram_fifo.sv ----
module test_dual_port_ram_fifo;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int DEPTH = dpf_pkg::DRAIN_DEPTH;
	logic mclk = 0, reset_n = 0, clear_n = 1, writeReq = 0, readReq = 0;
	logic drainSlow = 0, fillSlow = 0, drainPrev = 0, fillPrev = 0, expValid = 0, wPend = 0;
	logic [dpf_pkg::FILL_WIDTH-1:0] writeWordIn = '0;
	logic [dpf_pkg::DRAIN_WIDTH-1:0] readWordOut, expWord;
	logic readValid, empty, full, drainSideClock, fillSideClock;
	logic [dpf_pkg::DRAIN_WIDTH-1:0] q[$];
	int errorCnt = 0, nChecks = 0, seed = 32'h53d2, phase = 0;
	initial forever #5 mclk = ~mclk;
	dpf_fifo i_dpf_fifo (.mclk(mclk), .reset_n(reset_n), .drainSideClock(drainSideClock),
		.fillSideClock(fillSideClock), .clear_n(clear_n), .writeReq(writeReq),
		.readReq(readReq), .writeWordIn(writeWordIn), .readWordOut(readWordOut),
		.readValid(readValid), .empty(empty), .full(full));
	dpf_side_clk i_dpf_side_clk (.mclk(mclk), .reset_n(reset_n), .slow(drainSlow),
		.sideClk(drainSideClock));
	dpf_side_clk i_dpf_side_clk_fill (.mclk(mclk), .reset_n(reset_n), .slow(fillSlow),
		.sideClk(fillSideClock));
	// ----------------------------------------
	// compare and report
	// ----------------------------------------
	task checkBit(string name, logic exp, logic got);
		nChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("BAD %s exp %b got %b", name, exp, got);
		end
	endtask : checkBit
	task checkWord(string name, logic [7:0] exp, logic [7:0] got);
		nChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("BAD %s exp %h got %h", name, exp, got);
		end
	endtask : checkWord
	// a taken word counts toward empty only once the array holds it
	function automatic logic expEmpty(int size, logic pend);
		return size == int'(pend);
	endfunction : expEmpty
	function automatic logic expFull(int size);
		return size == DEPTH;
	endfunction : expFull
	task endOfTest();
		$display("checks %0d errors %0d", nChecks, errorCnt);
		if (errorCnt == 0 && nChecks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : endOfTest
	// ----------------------------------------
	// reference queue and random stimulus
	// ----------------------------------------
	// reads may follow a write at once: the fifo must guard the slot itself
	always @(posedge mclk) begin
		logic wTake, rTake;
		wTake = reset_n && clear_n && fillSideClock && !fillPrev && writeReq && q.size() < DEPTH;
		rTake = reset_n && clear_n && drainSideClock && !drainPrev && readReq
			&& !expEmpty(q.size(), wPend);
		wPend <= wTake;
		fillPrev <= reset_n & fillSideClock;
		drainPrev <= reset_n & drainSideClock;
		expValid <= rTake;
		if (rTake) expWord <= q.pop_front();
		if (wTake) q.push_back(writeWordIn);
		if (!reset_n || !clear_n) q.delete();
		writeWordIn <= 8'($random(seed));
		writeReq <= phase != 2 && (phase == 1 || ($random(seed) & 1));
		readReq <= phase != 1 && (phase == 2 || ($random(seed) & 1));
	end
	// settled outputs against the queue
	always @(negedge mclk) begin
		if (reset_n) begin
			checkBit("empty", expEmpty(q.size(), wPend), empty);
			checkBit("full", expFull(q.size()), full);
			checkBit("readValid", expValid, readValid);
			if (expValid) checkWord("readWordOut", expWord, readWordOut);
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge mclk);
		reset_n <= 1;
		for (int r = 0; r < 4; r++) begin
			drainSlow <= r[0];
			fillSlow <= r[1];
			phase <= 1;
			repeat (400) @(posedge mclk);
			@(negedge mclk) checkBit("full", 1'b1, full);
			@(posedge mclk) clear_n <= 0;
			repeat (2) @(posedge mclk);
			clear_n <= 1;
			@(negedge mclk) checkBit("empty", 1'b1, empty);
			repeat (400) @(posedge mclk);
			phase <= 2;
			repeat (400) @(posedge mclk);
			@(negedge mclk) checkBit("empty", 1'b1, empty);
			phase <= 0;
			repeat (300) @(posedge mclk);
		end
		endOfTest();
	end
endmodule : test_dual_port_ram_fifo
